// ===== core/rx_ctl_pkg.sv
// Constants and types shared by the receiver serial control block
package rx_ctl_pkg;

  localparam int ADDR_BITS  = 6;
  localparam int REG_BITS   = 12;
  localparam int CF_BITS    = 18;
  localparam int STD_XFER   = 18;
  localparam int CF_XFER    = 24;
  localparam int CNT_BITS   = 6;
  localparam int CAL_DIV    = 16;
  localparam int OFF_PER_W  = 8;
  localparam int MUTE_PER_W = 10;

  localparam logic [5:0] ADDR_ONE   = 6'h20;
  localparam logic [5:0] ADDR_TWO   = 6'h21;
  localparam logic [5:0] ADDR_THREE = 6'h22;
  localparam logic [5:0] ADDR_FOUR  = 6'h23;
  localparam logic [5:0] ADDR_FIVE  = 6'h24;
  localparam logic [5:0] ADDR_CF    = 6'h25;
  localparam logic [5:0] ADDR_RESET = 6'h1f;

  localparam logic [11:0] RST_ONE   = 12'h044;
  localparam logic [11:0] RST_TWO   = 12'h400;
  localparam logic [11:0] RST_THREE = 12'h080;
  localparam logic [11:0] RST_FOUR  = 12'h124;
  localparam logic [11:0] RST_FIVE  = 12'h60a;
  localparam logic [17:0] RST_CF    = 18'h0a0f0;

  // Writable bits; reserved bits stay zero
  localparam logic [11:0] MASK_ONE   = 12'h7ff;
  localparam logic [11:0] MASK_TWO   = 12'hfbf;
  localparam logic [11:0] MASK_THREE = 12'h3fc;
  localparam logic [11:0] MASK_FOUR  = 12'h3ff;
  localparam logic [11:0] MASK_FIVE  = 12'he0f;

  localparam int ONE_CLK_HALF = 5;
  localparam int ONE_OSC_SEL  = 4;
  localparam int ONE_OSC_ON   = 3;
  localparam int ONE_BUF_SRC  = 2;
  localparam int ONE_TEST_LSB = 0;
  localparam int TWO_KICK     = 11;
  localparam int TWO_AUTO     = 10;
  localparam int TWO_MUTE     = 9;
  localparam int TWO_SW_OVR   = 8;
  localparam int TWO_TX_OVR   = 7;
  localparam int TWO_CALV_LSB = 4;
  localparam int TWO_TXV_LSB  = 2;
  localparam int TWO_GPO_LSB  = 0;
  localparam int THREE_PER_LSB = 2;
  localparam int FOUR_PER_LSB  = 0;

  localparam logic [1:0] TEST_NORMAL = 2'h0;
  localparam logic [1:0] TEST_SHIFT  = 2'h1;
  localparam logic [1:0] TEST_OSCCNT = 2'h2;
  localparam logic [1:0] TEST_CNT2   = 2'h3;

  typedef struct packed {
    logic       transmit_band_select;
    logic       buffer_soft_enable;
    logic [2:0] amp_input_select;
    logic       oscillator_band_route;
    logic [3:0] filter_fine_gain;
    logic [1:0] filter_coarse_atten;
    logic       stage_two_gain_step;
    logic       stage_three_gain_step;
    logic [1:0] output_buffer_gain;
    logic       zero_if_select;
    logic       amp_bypass;
  } filter_gain_s;

endpackage : rx_ctl_pkg

// ===== core/cal_timer.sv
// Calibration interval timer counting divided calibration clock ticks
`timescale 1ns/1ps
`default_nettype none
module cal_timer #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst_q,
  input  wire logic         start,
  input  wire logic         tick,
  input  wire logic [W-1:0] period,
  output var  logic         running,
  output var  logic         done
);
  logic [W-1:0] count;

  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      count   <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count   <= '0;
        running <= 1'b1;
      end else if (running && tick) begin
        // A period of zero ends at the first tick
        if ({1'b0, count} + 1'b1 >= {1'b0, period}) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule : cal_timer
`default_nettype wire

// ===== core/rx_serial_control.sv
// Serial register bank, calibration timers and output override logic
// Notes on behaviour
// - Receive enable rise with switch override on forces outputs until mute timer ends, except while transmit override drives them.
// - During that window output 1 is value bit 0, output 2 bit 1.
// - Transmit override drives outputs from its value while transmit enable is high.
// - Otherwise outputs follow the general output field bits 0 and 1.
// - First six bits address registers 0x20..0x25; 0x26 and 0x27 are reserved.
// - Ordinary transfer is 18 bits; filter gain transfer is 24 bits.
// - Padding may sit between address and data; data is the final bits.
// - Writing the reset address restores every register default.
// - Select idles high, goes low for a transfer; bits taken on clock rise.
// - Shifted data lands in a register only on select rising.
// - Halving bit divides the calibration clock input by two.
// - Oscillator follows receive enable, or the soft-on bit when source select set.
// - Transmit buffers follow transmit enable or filter register bit 16.
// - Test select picks normal, shift data, oscillator counter MSB or counter two.
// - Kick bit starts calibration on load then clears itself; needs receive enable.
// - Automatic bit starts calibration on every receive enable rise.
// - Amplifier mute bit disables all amplifiers during the mute period.
// - Offset period counts divided ticks, then offset cancel loop freezes.
// - Mute period counts divided ticks, then amplifiers and switches return.
// - Amplifier select enables one amplifier for codes 0..3, none for 4 and 5.
// - Zero-IF bit picks low-IF or direct conversion; bypass bit bypasses amplifier.
// - Timers advance once per 16 calibration clock cycles after halving.
// - Offset result holds after the period until next calibration.
// - Receive enable high activates the chip, low deactivates it.
`timescale 1ns/1ps
`default_nettype none
module rx_serial_control
  import rx_ctl_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  input  wire logic   serial_select_n,
  input  wire logic   serial_clock,
  input  wire logic   serial_data_input,
  input  wire logic   cal_clock_in,
  input  wire logic   receive_enable,
  input  wire logic   transmit_enable,
  input  wire logic   osc_cal_count_msb,
  output var  logic   general_output_1,
  output var  logic   general_output_2,
  output var  logic [3:0] amp_enable,
  output var  logic   amp_bypass,
  output var  logic   low_if_mode,
  output var  logic   direct_conversion_mode,
  output var  logic   oscillator_on,
  output var  logic   tx_buffer_enable,
  output var  logic   transmit_band_select,
  output var  logic   chip_active,
  output var  logic   offset_cancel_run,
  output var  filter_gain_s filter_gain,
  output var  logic [11:0] trim_config,
  output var  logic [11:0] bias_config
);

  typedef enum logic {SER_IDLE, SER_SHIFT} ser_state_e;

  logic       rst_s1;
  logic       rst_q;
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic [6:0] pin_d;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_q  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_q  <= rst_s1;
    end
  end

  // Pin synchronisers; pin_d is a delayed copy for edge detection
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      pin_s1 <= 7'h01;
      pin_s2 <= 7'h01;
      pin_d  <= 7'h01;
    end else begin
      pin_s1 <= {osc_cal_count_msb, transmit_enable, receive_enable, cal_clock_in,
                 serial_data_input, serial_clock, serial_select_n};
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  logic sel_n_s;
  logic sclk_rise;
  logic sdi_s;
  logic cal_rise;
  logic rx_s;
  logic rx_rise;
  logic tx_s;
  logic osc_msb_s;
  logic sel_rise;

  assign sel_n_s   = pin_s2[0];
  assign sclk_rise = pin_s2[1] & ~pin_d[1];
  assign sdi_s     = pin_s2[2];
  assign cal_rise  = pin_s2[3] & ~pin_d[3];
  assign rx_s      = pin_s2[4];
  assign rx_rise   = pin_s2[4] & ~pin_d[4];
  assign tx_s      = pin_s2[5];
  assign osc_msb_s = pin_s2[6];
  assign sel_rise  = pin_s2[0] & ~pin_d[0];

  // Serial shifter
  ser_state_e          ser_state;
  logic [CNT_BITS-1:0] bit_count;
  logic [5:0]          addr;
  logic [CF_BITS-1:0]  shift;

  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      ser_state <= SER_IDLE;
      bit_count <= '0;
      addr      <= '0;
      shift     <= '0;
    end else begin
      unique case (ser_state)
        SER_IDLE: begin
          if (!sel_n_s) begin
            ser_state <= SER_SHIFT;
            bit_count <= '0;
          end
        end
        SER_SHIFT: begin
          if (sel_n_s) begin
            ser_state <= SER_IDLE;
          end else if (sclk_rise) begin
            if (bit_count < CNT_BITS'(ADDR_BITS)) begin
              addr <= {addr[4:0], sdi_s};
            end
            shift <= {shift[CF_BITS-2:0], sdi_s};
            if (bit_count != '1) begin
              bit_count <= bit_count + 1'b1;
            end
          end
        end
      endcase
    end
  end

  logic load_std;
  logic load_cf;
  logic load_rst;

  // Commit only on select rising, with enough bits for the target
  assign load_std = sel_rise && ser_state == SER_SHIFT
                    && bit_count >= CNT_BITS'(STD_XFER);
  assign load_cf  = sel_rise && ser_state == SER_SHIFT
                    && bit_count >= CNT_BITS'(CF_XFER) && addr == ADDR_CF;
  assign load_rst = sel_rise && ser_state == SER_SHIFT
                    && bit_count >= CNT_BITS'(ADDR_BITS) && addr == ADDR_RESET;

  logic [11:0]  cfg_one;
  logic [11:0]  cfg_two;
  logic [11:0]  cfg_three;
  logic [11:0]  cfg_four;
  logic [11:0]  cfg_five;
  filter_gain_s cfg_cf;
  logic [11:0]  wdata;

  assign wdata = shift[REG_BITS-1:0];

  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      cfg_one   <= RST_ONE;
      cfg_two   <= RST_TWO;
      cfg_three <= RST_THREE;
      cfg_four  <= RST_FOUR;
      cfg_five  <= RST_FIVE;
      cfg_cf    <= filter_gain_s'(RST_CF);
    end else if (load_rst) begin
      cfg_one   <= RST_ONE;
      cfg_two   <= RST_TWO;
      cfg_three <= RST_THREE;
      cfg_four  <= RST_FOUR;
      cfg_five  <= RST_FIVE;
      cfg_cf    <= filter_gain_s'(RST_CF);
    end else begin
      // Reserved addresses match nothing and reserved bits are masked
      if (load_std && addr == ADDR_ONE) cfg_one <= wdata & MASK_ONE;
      if (load_std && addr == ADDR_TWO) begin
        cfg_two <= wdata & MASK_TWO;
      end else if (cfg_two[TWO_KICK]) begin
        cfg_two[TWO_KICK] <= 1'b0;
      end
      if (load_std && addr == ADDR_THREE) cfg_three <= wdata & MASK_THREE;
      if (load_std && addr == ADDR_FOUR) cfg_four <= wdata & MASK_FOUR;
      if (load_std && addr == ADDR_FIVE) cfg_five <= wdata & MASK_FIVE;
      if (load_cf) cfg_cf <= filter_gain_s'(shift);
    end
  end

  // Calibration time base
  logic       half_phase;
  logic       cal_pulse;
  logic [3:0] div_count;
  logic       cal_tick;

  assign cal_pulse = cal_rise & (~cfg_one[ONE_CLK_HALF] | half_phase);

  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      half_phase <= 1'b0;
      div_count  <= '0;
      cal_tick   <= 1'b0;
    end else begin
      if (cal_rise) half_phase <= ~half_phase;
      cal_tick <= 1'b0;
      if (cal_pulse) begin
        div_count <= div_count + 1'b1;
        if (div_count == 4'(CAL_DIV - 1)) cal_tick <= 1'b1;
      end
    end
  end

  logic cal_start;
  logic mute_start;
  logic off_running;
  logic mute_running;
  logic mute_done;

  assign cal_start  = (cfg_two[TWO_AUTO] & rx_rise)
                      | (cfg_two[TWO_KICK] & rx_s);
  assign mute_start = cal_start | rx_rise;

  cal_timer #(.W(OFF_PER_W)) u_off_timer (
    .core_clk (core_clk),
    .rst_q    (rst_q),
    .start    (cal_start),
    .tick     (cal_tick),
    .period   (cfg_three[THREE_PER_LSB +: OFF_PER_W]),
    .running  (off_running),
    .done     ()
  );

  cal_timer #(.W(MUTE_PER_W)) u_mute_timer (
    .core_clk (core_clk),
    .rst_q    (rst_q),
    .start    (mute_start),
    .tick     (cal_tick),
    .period   (cfg_four[FOUR_PER_LSB +: MUTE_PER_W]),
    .running  (mute_running),
    .done     (mute_done)
  );

  // Calibration override window
  logic cal_ovr;
  logic tx_ovr;

  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      cal_ovr <= 1'b0;
    end else if (rx_rise && cfg_two[TWO_SW_OVR]) begin
      cal_ovr <= 1'b1;
    end else if (mute_done) begin
      cal_ovr <= 1'b0;
    end
  end

  assign tx_ovr = cfg_two[TWO_TX_OVR] & tx_s;

  logic [1:0] next_gpo;
  logic [3:0] next_amp;

  always_comb begin
    if (tx_ovr) begin
      next_gpo = cfg_two[TWO_TXV_LSB +: 2];
    end else if (cal_ovr) begin
      next_gpo = cfg_two[TWO_CALV_LSB +: 2];
    end else begin
      next_gpo = cfg_two[TWO_GPO_LSB +: 2];
    end
    unique case (cfg_one[ONE_TEST_LSB +: 2])
      TEST_NORMAL: next_gpo[0] = next_gpo[0];
      TEST_SHIFT:  next_gpo[0] = shift[0];
      TEST_OSCCNT: next_gpo[0] = osc_msb_s;
      TEST_CNT2:   next_gpo[0] = mute_running;
    endcase
    next_amp = 4'h0;
    if (!cfg_cf.amp_input_select[2]) begin
      next_amp[cfg_cf.amp_input_select[1:0]] = 1'b1;
    end
    if (cfg_two[TWO_MUTE] && mute_running) begin
      next_amp = 4'h0;
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      general_output_1       <= 1'b0;
      general_output_2       <= 1'b0;
      amp_enable             <= 4'h0;
      amp_bypass             <= 1'b0;
      low_if_mode            <= 1'b1;
      direct_conversion_mode <= 1'b0;
      oscillator_on          <= 1'b0;
      tx_buffer_enable       <= 1'b0;
      transmit_band_select   <= 1'b0;
      chip_active            <= 1'b0;
      offset_cancel_run      <= 1'b0;
      filter_gain            <= filter_gain_s'(RST_CF);
      trim_config            <= RST_ONE;
      bias_config            <= RST_FIVE;
    end else begin
      general_output_1       <= next_gpo[0];
      general_output_2       <= next_gpo[1];
      amp_enable             <= next_amp;
      amp_bypass             <= cfg_cf.amp_bypass;
      low_if_mode            <= ~cfg_cf.zero_if_select;
      direct_conversion_mode <= cfg_cf.zero_if_select;
      oscillator_on          <= cfg_one[ONE_OSC_SEL] ? cfg_one[ONE_OSC_ON] : rx_s;
      tx_buffer_enable       <= cfg_one[ONE_BUF_SRC] ? tx_s
                                : cfg_cf.buffer_soft_enable;
      transmit_band_select   <= cfg_cf.transmit_band_select;
      chip_active            <= rx_s;
      // Loop frozen when low; the result is held analog side
      offset_cancel_run      <= off_running;
      filter_gain            <= cfg_cf;
      trim_config            <= cfg_one;
      bias_config            <= cfg_five;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_q);

  sequence s_kick_load;
    load_std && addr == ADDR_TWO && wdata[TWO_KICK];
  endsequence

  sequence s_kick_cleared;
    ##1 cfg_two[TWO_KICK] ##1 !cfg_two[TWO_KICK];
  endsequence

  AST_CAL_OVR: assert property (cal_ovr && !tx_ovr && cfg_one[1:0] == TEST_NORMAL
    |=> general_output_2 == $past(cfg_two[TWO_CALV_LSB + 1])
        && general_output_1 == $past(cfg_two[TWO_CALV_LSB]))
    else $error("calibration override value not on outputs");

  AST_OVR_START: assert property (rx_rise && cfg_two[TWO_SW_OVR] |=> cal_ovr)
    else $error("override window did not open");

  AST_TX_OVR: assert property (tx_ovr |=> general_output_2 == $past(cfg_two[TWO_TXV_LSB + 1]))
    else $error("transmit override value not on output 2");

  AST_NORMAL: assert property (!tx_ovr && !cal_ovr
    |=> general_output_2 == $past(cfg_two[TWO_GPO_LSB + 1]))
    else $error("output 2 does not follow general field");

  AST_RESET_ADDR: assert property (load_rst |=> cfg_four == RST_FOUR && cfg_one == RST_ONE)
    else $error("reset address did not restore defaults");

  AST_LATCH: assert property (!sel_rise |=> $stable(cfg_three))
    else $error("register changed without select rising");

  AST_KICK: assert property (s_kick_load |-> s_kick_cleared)
    else $error("kick bit did not clear itself");

  AST_AUTO: assert property (cfg_two[TWO_AUTO] && rx_rise |=> off_running && mute_running)
    else $error("automatic calibration did not start");

  AST_MUTE: assert property (cfg_two[TWO_MUTE] && mute_running |=> amp_enable == 4'h0)
    else $error("amplifiers not muted during calibration");

  AST_AMP: assert property ($onehot0(amp_enable))
    else $error("more than one amplifier enabled");

  AST_TICK: assert property (cal_tick |=> !cal_tick [*8])
    else $error("calibration tick too frequent");

endmodule : rx_serial_control
`default_nettype wire

// ===== tb/serial_host.sv
// Host model that drives the three-wire serial port of the receiver
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  input  wire logic core_clk,
  output var  logic serial_select_n,
  output var  logic serial_clock,
  output var  logic serial_data_input
);
  initial begin
    serial_select_n   = 1'b1;
    serial_clock      = 1'b0;
    serial_data_input = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_n

  // One bit: data settles while the clock is low, taken on the rise
  task automatic put(input logic b);
    serial_data_input = b;
    wait_n(3);
    serial_clock = 1'b1;
    wait_n(3);
    serial_clock = 1'b0;
  endtask : put

  // Address, zero padding, then the low nd bits of data, MSB first
  task automatic send(input logic [5:0] addr, input int npad, input logic [17:0] data,
                      input int nd);
    serial_select_n = 1'b0;
    wait_n(3);
    for (int i = 5; i >= 0; i--) put(addr[i]);
    for (int i = 0; i < npad; i++) put(1'b0);
    for (int i = nd - 1; i >= 0; i--) put(data[i]);
    serial_select_n = 1'b1;
    // Released line shows the inverse of its last value
    serial_data_input = ~serial_data_input;
    wait_n(8);
  endtask : send
endmodule : serial_host
`default_nettype wire

// ===== tb/test_rx_serial_control.sv
// Self-checking bench for the receiver serial control block
`timescale 1ns/1ps
`default_nettype none
module test_rx_serial_control;
  import rx_ctl_pkg::*;

  logic         core_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         cal_clock_in = 1'b0;
  logic         receive_enable = 1'b0;
  logic         transmit_enable = 1'b0;
  logic         osc_cal_count_msb = 1'b0;
  wire          serial_select_n;
  wire          serial_clock;
  wire          serial_data_input;
  logic         general_output_1;
  logic         general_output_2;
  logic [3:0]   amp_enable;
  logic         amp_bypass;
  logic         low_if_mode;
  logic         direct_conversion_mode;
  logic         oscillator_on;
  logic         tx_buffer_enable;
  logic         transmit_band_select;
  logic         chip_active;
  logic         offset_cancel_run;
  filter_gain_s filter_gain;
  logic [11:0]  trim_config;
  logic [11:0]  bias_config;
  int           n_mismatch = 0;
  int           n_tests = 0;

  always #20 core_clk = ~core_clk;

  // Calibration clock: four core cycles per period
  always begin
    repeat (2) @(negedge core_clk);
    cal_clock_in = ~cal_clock_in;
  end

  serial_host host_u (
    .core_clk          (core_clk),
    .serial_select_n   (serial_select_n),
    .serial_clock      (serial_clock),
    .serial_data_input (serial_data_input)
  );

  rx_serial_control dut_u (
    .core_clk               (core_clk),
    .rst_n                  (rst_n),
    .serial_select_n        (serial_select_n),
    .serial_clock           (serial_clock),
    .serial_data_input      (serial_data_input),
    .cal_clock_in           (cal_clock_in),
    .receive_enable         (receive_enable),
    .transmit_enable        (transmit_enable),
    .osc_cal_count_msb      (osc_cal_count_msb),
    .general_output_1       (general_output_1),
    .general_output_2       (general_output_2),
    .amp_enable             (amp_enable),
    .amp_bypass             (amp_bypass),
    .low_if_mode            (low_if_mode),
    .direct_conversion_mode (direct_conversion_mode),
    .oscillator_on          (oscillator_on),
    .tx_buffer_enable       (tx_buffer_enable),
    .transmit_band_select   (transmit_band_select),
    .chip_active            (chip_active),
    .offset_cancel_run      (offset_cancel_run),
    .filter_gain            (filter_gain),
    .trim_config            (trim_config),
    .bias_config            (bias_config)
  );

  task automatic test_done;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // Bounded wait of up to 500 cycles until the outputs equal want; returns cycles spent
  task automatic wait_gpo(input logic [1:0] want, output int k);
    k = 0;
    while ({general_output_2, general_output_1} !== want && k < 500) begin
      cyc(1);
      k++;
    end
    if (k == 500) begin
      n_mismatch++;
      test_done();
    end
  endtask : wait_gpo

  task automatic t_regs;
    host_u.send(ADDR_ONE, 0, 18'h00fff, 12);
    check(trim_config, 18'h007ff);
    check(oscillator_on, 1'b1);
    host_u.send(ADDR_FIVE, 6, 18'h00fff, 12);
    check(bias_config, 18'h00e0f);
    host_u.send(ADDR_ONE, 0, 18'h00000, 11);
    check(trim_config, 18'h007ff);
    host_u.send(6'h26, 0, 18'h00000, 12);
    check(trim_config, 18'h007ff);
    check(bias_config, 18'h00e0f);
    host_u.send(ADDR_RESET, 0, 18'h00000, 12);
    check(trim_config, RST_ONE);
    check(bias_config, RST_FIVE);
    check(filter_gain, RST_CF);
    check(oscillator_on, 1'b0);
  endtask : t_regs

  task automatic t_gpo;
    host_u.send(ADDR_TWO, 0, 18'h00486, 12);
    check({general_output_2, general_output_1}, 2'b10);
    transmit_enable = 1'b1;
    cyc(8);
    check({general_output_2, general_output_1}, 2'b01);
    check(tx_buffer_enable, 1'b1);
    transmit_enable = 1'b0;
    cyc(8);
    check({general_output_2, general_output_1}, 2'b10);
    check(tx_buffer_enable, 1'b0);
  endtask : t_gpo

  task automatic t_filter;
    logic [17:0] d;
    host_u.send(ADDR_ONE, 0, 18'h00040, 12);
    for (int c = 5; c >= 0; c--) begin
      d = {1'b1, 1'b1, 3'(c), 13'h00f3};
      host_u.send(ADDR_CF, 0, d, 18);
      check(filter_gain, d);
      check(amp_enable, (c < 4) ? 4'(1 << c) : 4'h0);
      check({direct_conversion_mode, low_if_mode, amp_bypass}, 3'b101);
      check({tx_buffer_enable, transmit_band_select}, 2'b11);
    end
  endtask : t_filter

  task automatic t_test_sel;
    host_u.send(ADDR_ONE, 0, 18'h00045, 12);
    check(general_output_1, 1'b1);
    host_u.send(ADDR_ONE, 0, 18'h00046, 12);
    osc_cal_count_msb = 1'b1;
    cyc(8);
    check(general_output_1, 1'b1);
    osc_cal_count_msb = 1'b0;
    cyc(8);
    check(general_output_1, 1'b0);
    host_u.send(ADDR_ONE, 0, {6'h0, RST_ONE}, 12);
  endtask : t_test_sel

  task automatic t_cal;
    int k;
    host_u.send(ADDR_THREE, 0, 18'h0000c, 12);
    host_u.send(ADDR_FOUR, 0, 18'h00003, 12);
    host_u.send(ADDR_TWO, 0, 18'h0079a, 12);
    check(amp_enable, 4'h1);
    receive_enable = 1'b1;
    cyc(10);
    check({general_output_2, general_output_1}, 2'b01);
    check(amp_enable, 4'h0);
    check({chip_active, oscillator_on, offset_cancel_run}, 3'b111);
    transmit_enable = 1'b1;
    cyc(8);
    check({general_output_2, general_output_1}, 2'b10);
    transmit_enable = 1'b0;
    cyc(8);
    check({general_output_2, general_output_1}, 2'b01);
    wait_gpo(2'b10, k);
    // Three ticks of 64 core cycles each, from a free-running tick phase
    check((k + 26 >= 120) && (k + 26 <= 210), 1'b1);
    check(amp_enable, 4'h1);
    check(offset_cancel_run, 1'b0);
    host_u.send(ADDR_ONE, 0, 18'h00067, 12);
    host_u.send(ADDR_TWO, 0, 18'h00f9a, 12);
    // Kick restarts both timers; without a receive enable rise there is no override
    check({general_output_2, general_output_1, amp_enable, offset_cancel_run}, 7'b1100001);
    wait_gpo(2'b10, k);
    // Halved input: three ticks of 128 core cycles each
    check((k >= 200) && (k <= 400), 1'b1);
    receive_enable = 1'b0;
    cyc(8);
    check({chip_active, oscillator_on}, 2'b00);
  endtask : t_cal

  initial begin
    #(40 * 100000);
    n_mismatch++;
    test_done();
  end

  initial begin
    cyc(2);
    rst_n = 1'b1;
    cyc(8);
    check(filter_gain, RST_CF);
    check({general_output_2, general_output_1, low_if_mode}, 3'b001);
    host_u.send(ADDR_RESET, 0, 18'h00000, 12);
    t_regs();
    t_gpo();
    t_filter();
    t_test_sel();
    t_cal();
    test_done();
  end
endmodule : test_rx_serial_control
`default_nettype wire
